// File: pkg/sau_pkg.sv
/*
  Constants, opcode encoding and shared types for the saturating arithmetic unit.
  Assumes a single core clock domain; included by the unit and its lane module.
*/
package sau_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned SAU_WORD_W = 32;
  localparam int unsigned SAU_HALF_W = 16;
  localparam int unsigned SAU_BYTE_W = 8;
  localparam int unsigned SAU_SAT_W = 6;
  localparam int unsigned SAU_SHIFT_W = 5;

  // ---------------------------------------------------------------
  // legal ranges of the width and shift fields
  // ---------------------------------------------------------------
  localparam logic [5:0] SAU_SSAT_MIN = 6'h01;
  localparam logic [5:0] SAU_SSAT_MAX = 6'h20;
  localparam logic [5:0] SAU_USAT_MAX = 6'h1F;
  localparam logic [5:0] SAU_SIGNED_CLAMP_PAIR_MAX = 6'h10;
  localparam logic [5:0] SAU_UNSIGNED_CLAMP_PAIR_MAX = 6'h0F;
  localparam logic [4:0] SAU_ASR_MIN = 5'h01;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic SAU_STICKY_RST = 1'b0;
  localparam logic [31:0] SAU_RESULT_RST = 32'h0000_0000;
  localparam logic [3:0] SAU_FLAGS_RST = 4'h0;

  // operation codes from the decode stage
  typedef enum logic [3:0] {
    SAU_OP_SCLAMP = 4'h0,
    SAU_OP_UCLAMP = 4'h1,
    SAU_OP_SCLAMP_PAIR = 4'h2,
    SAU_OP_UCLAMP_PAIR = 4'h3,
    SAU_OP_ADD_WORD = 4'h4,
    SAU_OP_SUB_WORD = 4'h5,
    SAU_OP_ADD_HALVES = 4'h6,
    SAU_OP_SUB_HALVES = 4'h7,
    SAU_OP_ADD_BYTES = 4'h8,
    SAU_OP_SUB_BYTES = 4'h9
  } sau_op_t;

  // lane size of the add/subtract datapath
  typedef enum logic [1:0] {
    SAU_LANE_WORD = 2'h0,
    SAU_LANE_HALF = 2'h1,
    SAU_LANE_BYTE = 2'h2
  } sau_lane_t;

  // issue pipeline states, one-hot
  typedef enum logic [1:0] {
    SAU_ST_IDLE = 2'b01,
    SAU_ST_DONE = 2'b10
  } sau_state_t;
endpackage

// File: pkg/sau_lane_if.sv
/*
  Interface carrying operands and results between the unit and its lane adder.
  Assumes both ends sit in the same clock domain; purely combinational.
*/
interface sau_lane_if;
  import sau_pkg::*;
  logic [31:0] a;
  logic [31:0] b;
  logic sub;
  sau_lane_t lane;
  logic [31:0] sum;
  logic [3:0] lane_sat;

  modport master (output a, output b, output sub, output lane, input sum, input lane_sat);
  modport slave (input a, input b, input sub, input lane, output sum, output lane_sat);
endinterface

// File: design/sau_lane_addsub.sv
/*
  Lane-split signed saturating add/subtract: one word, two halves or four bytes.
  Assumes operands are stable for the cycle; no state is held here.
*/
module sau_lane_addsub
  import sau_pkg::*;
(
  sau_lane_if.slave lif
);

  // ---------------------------------------------------------------
  // clamp a 9-bit byte result to the signed 8-bit range, bit 8 marks a clamp
  // ---------------------------------------------------------------
  function automatic logic [8:0] sat8(input logic [8:0] v);
    logic [8:0] r;
    r = {1'b0, v[7:0]};
    if (v[8] != v[7]) begin
      r = {1'b1, v[8], {7{~v[8]}}};
    end
    return r;
  endfunction

  logic [8:0] byte_res [4];
  logic [16:0] half_res [2];
  logic [32:0] word_res;

  // each byte lane works alone, no carry crosses its edge
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_byte
      always_comb begin
        if (lif.sub) begin
          byte_res[g] = sat8({lif.a[8*g+7], lif.a[8*g +: 8]} - {lif.b[8*g+7], lif.b[8*g +: 8]}); // RULE13
        end else begin
          byte_res[g] = sat8({lif.a[8*g+7], lif.a[8*g +: 8]} + {lif.b[8*g+7], lif.b[8*g +: 8]}); // RULE13
        end
      end
    end
    for (g = 0; g < 2; g++) begin : g_half
      always_comb begin
        if (lif.sub) begin
          half_res[g] = {lif.a[16*g+15], lif.a[16*g +: 16]} - {lif.b[16*g+15], lif.b[16*g +: 16]}; // RULE13
        end else begin
          half_res[g] = {lif.a[16*g+15], lif.a[16*g +: 16]} + {lif.b[16*g+15], lif.b[16*g +: 16]}; // RULE13
        end
      end
    end
  endgenerate

  // full word sum with a guard bit for overflow detection
  assign word_res = lif.sub ? ({lif.a[31], lif.a} - {lif.b[31], lif.b}) : ({lif.a[31], lif.a} + {lif.b[31], lif.b});

  // lane selection and per-lane clamp
  always_comb begin
    lif.sum = SAU_RESULT_RST;
    lif.lane_sat = SAU_FLAGS_RST;
    case (lif.lane)
      SAU_LANE_WORD: begin
        lif.sum = word_res[31:0];
        if (word_res[32] != word_res[31]) begin
          lif.sum = {word_res[32], {31{~word_res[32]}}}; // RULE12
          lif.lane_sat[0] = 1'b1;
        end
      end
      SAU_LANE_HALF: begin
        for (int i = 0; i < 2; i++) begin
          lif.sum[16*i +: 16] = half_res[i][15:0];
          if (half_res[i][16] != half_res[i][15]) begin
            lif.sum[16*i +: 16] = {half_res[i][16], {15{~half_res[i][16]}}}; // RULE12
            lif.lane_sat[i] = 1'b1;
          end
        end
      end
      SAU_LANE_BYTE: begin
        for (int i = 0; i < 4; i++) begin
          lif.sum[8*i +: 8] = byte_res[i][7:0]; // RULE12
          lif.lane_sat[i] = byte_res[i][8];
        end
      end
      default: begin
        lif.sum = SAU_RESULT_RST;
      end
    endcase
  end
endmodule

// File: design/sau_unit.sv
/*
  Saturating arithmetic unit: shifted word clamps, halfword-pair clamps and
  lane-split signed saturating add/subtract, with a sticky overflow bit.
  Assumes the decode stage issues one request per valid pulse on the core clock
  and never names the stack pointer or program counter as an operand.
*/

// Overview of operation
// RULE1: a signed clamp returns the lower bound below range, the upper bound above it, else the input.
// RULE2: an unsigned clamp returns zero for negatives, two to the n minus one above it, else the input.
// RULE3: any clamp that changes its value sets the sticky overflow bit, otherwise the bit is kept.
// RULE4: the sticky bit is cleared only by an explicit write to the status register, never by an operation.
// RULE5: the word signed clamp takes widths one through thirty-two.
// RULE6: the word unsigned clamp takes widths zero through thirty-one.
// RULE7: before a word clamp the source may be shifted right arithmetically 1-31 or left logically 0-31.
// RULE8: the word signed clamp shifts first and then clamps the shifted value.
// RULE9: the word unsigned clamp treats its source as signed two's complement.
// RULE10: pair signed clamp takes widths one to sixteen, pair unsigned clamp zero to fifteen.
// RULE11: pair clamps treat the two halves independently and write each to its own half.
// RULE12: signed add and subtract work on 32, 16 or 8 bit lanes, each clamped to its signed range.
// RULE13: lane forms use four byte or two halfword lanes, saturated separately with no carry between lanes.
// RULE14: byte and halfword lane add and subtract never set the sticky bit; only word forms may.
// RULE15: no operation here changes the negative, zero, carry or overflow flags.
// RULE16: the decode stage must not use the stack pointer or program counter as operand.
module sau_unit
  import sau_pkg::*;
(
  clk,
  rst_b,
  clk_en,
  op_valid,
  op_code,
  first_operand_reg,
  second_operand_reg,
  sat_width,
  shift_amount,
  shift_is_asr,
  status_wr,
  status_wr_sticky,
  status_wr_nzcv,
  result,
  result_valid,
  op_illegal,
  sticky_ovf,
  nzcv_flags
);
  input wire logic clk;
  input wire logic rst_b;
  input wire logic clk_en;
  input wire logic op_valid;
  input wire sau_op_t op_code;
  input wire logic [31:0] first_operand_reg;
  input wire logic [31:0] second_operand_reg;
  input wire logic [5:0] sat_width;
  input wire logic [4:0] shift_amount;
  input wire logic shift_is_asr;
  input wire logic status_wr;
  input wire logic status_wr_sticky;
  input wire logic [3:0] status_wr_nzcv;
  output logic [31:0] result;
  output logic result_valid;
  output logic op_illegal;
  output logic sticky_ovf;
  output logic [3:0] nzcv_flags;

  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_b;

  // release after two edges so all flops leave reset together
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_b <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // clamp helpers
  // ---------------------------------------------------------------
  // signed clamp of a 33-bit signed value to n bits, n in 1..32
  function automatic logic [32:0] sclamp(input logic [32:0] v, input logic [5:0] n);
    logic signed [32:0] hi;
    logic signed [32:0] lo;
    logic [32:0] r;
    hi = 33'sh0_7FFF_FFFF >>> (6'd32 - n);
    lo = ~hi;
    r = v;
    if ($signed(v) > hi) begin
      r = hi; // RULE1
    end else if ($signed(v) < lo) begin
      r = lo; // RULE1
    end
    return r;
  endfunction

  // unsigned clamp of a 33-bit signed value to n bits, n in 0..31
  function automatic logic [32:0] uclamp(input logic [32:0] v, input logic [5:0] n);
    logic signed [32:0] hi;
    logic [32:0] r;
    hi = $signed((33'h1 << n) - 33'h1);
    r = v;
    if (v[32]) begin
      r = '0; // RULE2
    end else if ($signed(v) > hi) begin
      r = hi; // RULE2
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // width and shift checks
  // ---------------------------------------------------------------
  logic width_ok;

  always_comb begin
    case (op_code)
      SAU_OP_SCLAMP: width_ok = (sat_width >= SAU_SSAT_MIN) && (sat_width <= SAU_SSAT_MAX)
                                && !(shift_is_asr && shift_amount < SAU_ASR_MIN); // RULE5 RULE7
      SAU_OP_UCLAMP: width_ok = (sat_width <= SAU_USAT_MAX)
                                && !(shift_is_asr && shift_amount < SAU_ASR_MIN); // RULE6 RULE7
      SAU_OP_SCLAMP_PAIR: width_ok = (sat_width >= SAU_SSAT_MIN) && (sat_width <= SAU_SIGNED_CLAMP_PAIR_MAX); // RULE10
      SAU_OP_UCLAMP_PAIR: width_ok = (sat_width <= SAU_UNSIGNED_CLAMP_PAIR_MAX); // RULE10
      SAU_OP_ADD_WORD, SAU_OP_SUB_WORD, SAU_OP_ADD_HALVES,
      SAU_OP_SUB_HALVES, SAU_OP_ADD_BYTES, SAU_OP_SUB_BYTES: width_ok = 1'b1;
      default: width_ok = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // shifted source for the word clamps
  // ---------------------------------------------------------------
  logic [32:0] shifted;
  logic [31:0] shift_word;

  // shift at register width first: bits pushed past bit 31 are lost, as on the core shifter
  always_comb begin
    if (shift_is_asr) begin
      shift_word = $signed(second_operand_reg) >>> shift_amount; // RULE7 RULE8
    end else begin
      shift_word = second_operand_reg << shift_amount; // RULE7 RULE8
    end
    shifted = {shift_word[31], shift_word};
  end

  // ---------------------------------------------------------------
  // lane adder
  // ---------------------------------------------------------------
  sau_lane_if lif ();

  assign lif.a = first_operand_reg;
  assign lif.b = second_operand_reg;
  assign lif.sub = (op_code == SAU_OP_SUB_WORD) || (op_code == SAU_OP_SUB_HALVES) || (op_code == SAU_OP_SUB_BYTES);
  assign lif.lane = (op_code == SAU_OP_ADD_HALVES || op_code == SAU_OP_SUB_HALVES) ? SAU_LANE_HALF :
                    (op_code == SAU_OP_ADD_BYTES || op_code == SAU_OP_SUB_BYTES) ? SAU_LANE_BYTE : SAU_LANE_WORD;

  sau_lane_addsub u_lane (
    .lif(lif)
  );

  // ---------------------------------------------------------------
  // result and saturation select
  // ---------------------------------------------------------------
  logic [31:0] res_next;
  logic sat_next;
  logic [32:0] lo_c;
  logic [32:0] hi_c;

  always_comb begin
    res_next = SAU_RESULT_RST;
    sat_next = 1'b0;
    lo_c = '0;
    hi_c = '0;
    case (op_code)
      SAU_OP_SCLAMP: begin
        lo_c = sclamp(shifted, sat_width); // RULE8
        res_next = lo_c[31:0];
        sat_next = (lo_c != shifted); // RULE3
      end
      SAU_OP_UCLAMP: begin
        lo_c = uclamp(shifted, sat_width); // RULE9
        res_next = lo_c[31:0];
        sat_next = (lo_c != shifted); // RULE3
      end
      SAU_OP_SCLAMP_PAIR: begin
        lo_c = sclamp({{17{second_operand_reg[15]}}, second_operand_reg[15:0]}, sat_width); // RULE11
        hi_c = sclamp({{17{second_operand_reg[31]}}, second_operand_reg[31:16]}, sat_width); // RULE11
        res_next = {hi_c[15:0], lo_c[15:0]}; // RULE11
        sat_next = (lo_c[15:0] != second_operand_reg[15:0]) || (hi_c[15:0] != second_operand_reg[31:16]); // RULE3
      end
      SAU_OP_UCLAMP_PAIR: begin
        lo_c = uclamp({{17{second_operand_reg[15]}}, second_operand_reg[15:0]}, sat_width); // RULE11
        hi_c = uclamp({{17{second_operand_reg[31]}}, second_operand_reg[31:16]}, sat_width); // RULE11
        res_next = {hi_c[15:0], lo_c[15:0]}; // RULE11
        sat_next = (lo_c[15:0] != second_operand_reg[15:0]) || (hi_c[15:0] != second_operand_reg[31:16]); // RULE3
      end
      SAU_OP_ADD_WORD, SAU_OP_SUB_WORD: begin
        res_next = lif.sum; // RULE12
        sat_next = lif.lane_sat[0]; // RULE3
      end
      SAU_OP_ADD_HALVES, SAU_OP_SUB_HALVES, SAU_OP_ADD_BYTES, SAU_OP_SUB_BYTES: begin
        res_next = lif.sum; // RULE13
        sat_next = 1'b0; // RULE14
      end
      default: begin
        res_next = SAU_RESULT_RST;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // issue state
  // ---------------------------------------------------------------
  sau_state_t state_reg;
  logic take;

  assign take = op_valid && clk_en;

  // one cycle of latency: a taken request answers on the next edge
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_reg <= SAU_ST_IDLE;
    end else if (clk_en) begin
      case (state_reg)
        SAU_ST_IDLE: state_reg <= op_valid ? SAU_ST_DONE : SAU_ST_IDLE;
        SAU_ST_DONE: state_reg <= op_valid ? SAU_ST_DONE : SAU_ST_IDLE;
        default: state_reg <= SAU_ST_IDLE;
      endcase
    end
  end

  assign result_valid = (state_reg == SAU_ST_DONE);

  // result and error registers, updated only when a request is taken
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      result <= SAU_RESULT_RST;
      op_illegal <= 1'b0;
    end else if (take) begin
      result <= width_ok ? res_next : SAU_RESULT_RST;
      op_illegal <= !width_ok;
    end
  end

  // ---------------------------------------------------------------
  // status word bits
  // ---------------------------------------------------------------
  // sticky bit: a saturation in the same cycle as a clearing write wins
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sticky_ovf <= SAU_STICKY_RST;
    end else if (clk_en) begin
      if (take && width_ok && sat_next) begin
        sticky_ovf <= 1'b1; // RULE3
      end else if (status_wr) begin
        sticky_ovf <= status_wr_sticky; // RULE4
      end
    end
  end

  // condition flags change only through the status write path
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      nzcv_flags <= SAU_FLAGS_RST;
    end else if (clk_en && status_wr) begin
      nzcv_flags <= status_wr_nzcv; // RULE15
    end
  end
endmodule

// File: dv/sau_unit_assertions.sv
/*
  Port-level checker for the saturating arithmetic unit.
  Assumes one core clock and the raw async active-low reset.
*/
module sau_unit_assertions
  import sau_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic op_valid,
  input wire sau_op_t op_code,
  input wire logic [31:0] first_operand_reg,
  input wire logic [31:0] second_operand_reg,
  input wire logic [5:0] sat_width,
  input wire logic [4:0] shift_amount,
  input wire logic shift_is_asr,
  input wire logic status_wr,
  input wire logic status_wr_sticky,
  input wire logic [3:0] status_wr_nzcv,
  input wire logic [31:0] result,
  input wire logic result_valid,
  input wire logic op_illegal,
  input wire logic sticky_ovf,
  input wire logic [3:0] nzcv_flags
);
  // ----
  // reference helpers
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic tk;
  logic sw;
  logic signed [32:0] sum;
  logic signed [32:0] hi;
  logic signed [32:0] src;
  logic [31:0] add_sat;
  logic [31:0] scl;
  // a take and a status write only count on enabled edges
  assign tk = clk_en && op_valid;
  assign sw = clk_en && status_wr;
  assign sum = $signed({first_operand_reg[31], first_operand_reg}) + $signed({second_operand_reg[31], second_operand_reg});
  assign add_sat = (sum[32] != sum[31]) ? {sum[32], {31{!sum[32]}}} : sum[31:0];
  assign hi = (33'sd1 <<< (sat_width - 6'h01)) - 33'sd1;
  assign src = $signed({second_operand_reg[31], second_operand_reg});
  assign scl = (src > hi) ? hi[31:0] : ((src < -hi - 33'sd1) ? 32'(-hi - 33'sd1) : second_operand_reg);
  sequence s_sclamp;
    tk && op_code == SAU_OP_SCLAMP && !shift_is_asr && shift_amount == 5'h00 && sat_width inside {[6'h01:6'h20]};
  endsequence
  sequence s_add;
    tk && op_code == SAU_OP_ADD_WORD;
  endsequence
  property p_sclamp; s_sclamp |=> result == $past(scl) && !op_illegal; endproperty
  property p_uneg;
    tk && op_code == SAU_OP_UCLAMP && !shift_is_asr && shift_amount == 5'h00 && sat_width <= 6'h1F
      && second_operand_reg[31] |=> result == 32'h0;
  endproperty
  property p_add; s_add |=> result == $past(add_sat); endproperty
  property p_add_q; s_add and (sum[32] != sum[31]) |=> sticky_ovf; endproperty
  property p_keep; sticky_ovf && !sw |=> sticky_ovf; endproperty
  property p_lane; !sticky_ovf && !sw && !(tk && op_code <= SAU_OP_SUB_WORD) |=> !sticky_ovf; endproperty
  property p_nzcv; !sw |=> $stable(nzcv_flags); endproperty
  property p_nzcv_wr; sw |=> nzcv_flags == $past(status_wr_nzcv); endproperty
  property p_w0; tk && op_code == SAU_OP_SCLAMP && sat_width == 6'h00 |=> op_illegal && result == 32'h0; endproperty
  property p_asr0;
    tk && op_code inside {SAU_OP_SCLAMP, SAU_OP_UCLAMP} && shift_is_asr && shift_amount == 5'h00 |=> op_illegal;
  endproperty
  a_sclamp: assert property (p_sclamp) else $error("signed clamp result wrong");
  a_uneg: assert property (p_uneg) else $error("negative unsigned clamp not zero");
  a_add: assert property (p_add) else $error("word add not saturated");
  a_add_q: assert property (p_add_q) else $error("word add overflow left sticky low");
  a_keep: assert property (p_keep) else $error("sticky cleared by an operation");
  a_lane: assert property (p_lane) else $error("sticky set by lane operation");
  a_nzcv: assert property (p_nzcv) else $error("flags changed without write");
  a_nzcv_wr: assert property (p_nzcv_wr) else $error("flags write lost");
  a_w0: assert property (p_w0) else $error("width zero accepted");
  a_asr0: assert property (p_asr0) else $error("right shift of zero accepted");
endmodule

bind sau_unit sau_unit_assertions chk (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .op_valid(op_valid),
  .op_code(op_code), .first_operand_reg(first_operand_reg), .second_operand_reg(second_operand_reg),
  .sat_width(sat_width), .shift_amount(shift_amount), .shift_is_asr(shift_is_asr), .status_wr(status_wr),
  .status_wr_sticky(status_wr_sticky), .status_wr_nzcv(status_wr_nzcv), .result(result),
  .result_valid(result_valid), .op_illegal(op_illegal), .sticky_ovf(sticky_ovf), .nzcv_flags(nzcv_flags));

// File: dv/sau_dec_model.sv
/*
  Decode and register file model that issues requests to the unit.
  Assumes the bench loads registers before each issue call.
*/
module sau_dec_model
  import sau_pkg::*;
(
  input wire logic clk,
  output logic clk_en = 1'b1,
  output logic op_valid = 1'b0,
  output sau_op_t op_code = SAU_OP_SCLAMP,
  output logic [31:0] first_operand_reg = 32'h0,
  output logic [31:0] second_operand_reg = 32'h0,
  output logic [5:0] sat_width = 6'h0,
  output logic [4:0] shift_amount = 5'h0,
  output logic shift_is_asr = 1'b0,
  output logic status_wr = 1'b0,
  output logic status_wr_sticky = 1'b0,
  output logic [3:0] status_wr_nzcv = 4'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // register file and issue
  // ----
  logic [31:0] rf [0:15];
  // index 13 is the stack pointer and 15 the program counter: never issued
  task automatic issue(sau_op_t o, int ia, int ib, int n, int s, bit arith_shift_right, bit en);
    @(posedge clk);
    if (ia == 13 || ia == 15) ia = 0;
    if (ib == 13 || ib == 15) ib = 0;
    clk_en <= en;
    op_valid <= 1'b1;
    status_wr <= 1'b0;
    op_code <= o;
    first_operand_reg <= rf[ia];
    second_operand_reg <= rf[ib];
    sat_width <= 6'(n);
    shift_amount <= 5'(s);
    shift_is_asr <= arith_shift_right;
  endtask
  // status writes are kept apart from operations
  task automatic swr(bit st, logic [3:0] f);
    @(posedge clk);
    op_valid <= 1'b0;
    clk_en <= 1'b1;
    status_wr <= 1'b1;
    status_wr_sticky <= st;
    status_wr_nzcv <= f;
  endtask
  task automatic idle();
    @(posedge clk);
    op_valid <= 1'b0;
    status_wr <= 1'b0;
    clk_en <= 1'b1;
  endtask
endmodule

// File: dv/sau_unit_bench.sv
/*
  Self-checking bench for the saturating arithmetic unit.
  Assumes the decode model drives all requests; checker is bound.
*/
module sau_unit_bench
  import sau_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin error_cnt++; $display("wrong value %s exp %0h got %0h", nm, e, s); end end
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en, op_valid, shift_is_asr, status_wr, status_wr_sticky, result_valid, op_illegal, sticky_ovf;
  sau_op_t op_code;
  logic [31:0] first_operand_reg, second_operand_reg, result;
  logic [5:0] sat_width;
  logic [4:0] shift_amount;
  logic [3:0] status_wr_nzcv, nzcv_flags, nzcv_exp = 4'h0;
  logic [37:0] exp_q [$];
  logic [37:0] mon_e;
  bit sticky_exp = 1'b0;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  sau_dec_model dec (.clk(clk), .clk_en(clk_en), .op_valid(op_valid), .op_code(op_code),
    .first_operand_reg(first_operand_reg), .second_operand_reg(second_operand_reg), .sat_width(sat_width),
    .shift_amount(shift_amount), .shift_is_asr(shift_is_asr), .status_wr(status_wr),
    .status_wr_sticky(status_wr_sticky), .status_wr_nzcv(status_wr_nzcv));
  sau_unit uut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .op_valid(op_valid), .op_code(op_code),
    .first_operand_reg(first_operand_reg), .second_operand_reg(second_operand_reg), .sat_width(sat_width),
    .shift_amount(shift_amount), .shift_is_asr(shift_is_asr), .status_wr(status_wr),
    .status_wr_sticky(status_wr_sticky), .status_wr_nzcv(status_wr_nzcv), .result(result),
    .result_valid(result_valid), .op_illegal(op_illegal), .sticky_ovf(sticky_ovf), .nzcv_flags(nzcv_flags));
  // ----
  // reference arithmetic
  // ----
  function automatic longint sx(logic [31:0] x, int k, int w);
    logic [31:0] y;
    y = (x >> (k * w)) << (32 - w);
    return longint'($signed(y)) >>> (32 - w);
  endfunction
  function automatic longint clamp(longint v, int n, bit sg, inout bit f);
    longint hi;
    longint lo;
    hi = sg ? (64'sd1 <<< (n - 1)) - 1 : (64'sd1 <<< n) - 1;
    lo = sg ? -hi - 1 : 0;
    if (v > hi || v < lo) f = 1'b1;
    return (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction
  // returns {illegal, saturated, result}
  function automatic logic [33:0] ref_op(sau_op_t o, logic [31:0] a, logic [31:0] b, int n, int s, bit arith_shift_right);
    bit f;
    bit bad;
    int w;
    longint v;
    logic [31:0] r;
    f = 1'b0;
    r = 32'h0;
    case (o)
      SAU_OP_SCLAMP: bad = n < 1 || n > 32 || (arith_shift_right && s == 0);
      SAU_OP_UCLAMP: bad = n > 31 || (arith_shift_right && s == 0);
      SAU_OP_SCLAMP_PAIR: bad = n < 1 || n > 16;
      SAU_OP_UCLAMP_PAIR: bad = n > 15;
      default: bad = 1'b0;
    endcase
    w = (o inside {SAU_OP_ADD_BYTES, SAU_OP_SUB_BYTES}) ? 8 : ((o < 2 || o inside {4, 5}) ? 32 : 16);
    if (o < 2) b = arith_shift_right ? 32'($signed(b) >>> s) : b << s;
    for (int k = 0; k < 32 / w && !bad; k++) begin
      if (o < 4) v = clamp(sx(b, k, w), n, !o[0], f);
      else v = clamp(o[0] ? sx(a, k, w) - sx(b, k, w) : sx(a, k, w) + sx(b, k, w), w, 1'b1, f);
      r = r | ((32'(v) & (32'hFFFFFFFF >> (32 - w))) << (k * w));
    end
    return {bad, f && o < 6, r};
  endfunction
  // ----
  // drivers, monitor, verdict
  // ----
  task automatic run(sau_op_t o, logic [31:0] a, logic [31:0] b, int n, int s, bit arith_shift_right);
    int ia;
    logic [33:0] r;
    ia = $urandom % 13;
    dec.rf[ia] = a;
    dec.rf[(ia + 1) % 13] = b;
    r = ref_op(o, a, b, n, s, arith_shift_right);
    dec.issue(o, ia, (ia + 1) % 13, n, s, arith_shift_right, 1'b1);
    if (!r[33]) sticky_exp = sticky_exp | r[32];
    exp_q.push_back({nzcv_exp, r[33], sticky_exp, r[31:0]});
  endtask
  task automatic wst(bit st, logic [3:0] f);
    dec.swr(st, f);
    sticky_exp = st;
    nzcv_exp = f;
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  // results are settled by the falling edge
  always @(negedge clk) begin
    if (result_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK("result_valid", 1'b0, result_valid)
      else begin
        mon_e = exp_q.pop_front();
        `CHK("result", mon_e[31:0], result)
        `CHK("op_illegal", mon_e[33], op_illegal)
        `CHK("sticky_ovf", mon_e[32], sticky_ovf)
        `CHK("nzcv_flags", mon_e[37:34], nzcv_flags)
      end
    end
  end
  // hang guard well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    void'($urandom(73715));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    run(SAU_OP_SCLAMP, 0, 32'h1000, 8, 0, 0);
    wst(0, 4'hA);
    run(SAU_OP_ADD_BYTES, 32'h7F807F01, 32'h01FF8001, 0, 0, 0);
    run(SAU_OP_SUB_HALVES, 32'h80007FFF, 32'h0001FFFF, 0, 0, 0);
    run(SAU_OP_ADD_HALVES, 32'h7FFF0001, 32'h0001FFFF, 0, 0, 0);
    run(SAU_OP_SUB_BYTES, 32'h80007F10, 32'h7F01FF20, 0, 0, 0);
    run(SAU_OP_SCLAMP, 0, 32'h7FFFFFFF, 0, 0, 0);
    run(SAU_OP_UCLAMP, 0, 32'hFFFFFFFF, 32, 0, 0);
    run(SAU_OP_SCLAMP, 0, 32'h7FFFFFFF, 8, 0, 1);
    run(SAU_OP_SCLAMP_PAIR, 0, 32'h7FFF8000, 17, 0, 0);
    run(SAU_OP_UCLAMP_PAIR, 0, 32'h7FFF8000, 16, 0, 0);
    run(SAU_OP_SCLAMP, 0, 32'h80000000, 32, 31, 1);
    run(SAU_OP_UCLAMP, 0, 32'h1, 0, 0, 0);
    wst(0, 4'h5);
    run(SAU_OP_UCLAMP, 0, 32'h80000000, 31, 0, 0);
    run(SAU_OP_UCLAMP, 0, 32'hFFFFFFF0, 31, 4, 1);
    run(SAU_OP_SCLAMP, 0, 32'h1, 1, 31, 0);
    run(SAU_OP_SCLAMP_PAIR, 0, 32'h0100FE00, 9, 0, 0);
    run(SAU_OP_UCLAMP_PAIR, 0, 32'hFFFF0200, 15, 0, 0);
    wst(0, 4'h3);
    run(SAU_OP_ADD_WORD, 32'h7FFFFFFF, 32'h1, 0, 0, 0);
    wst(1, 4'hC);
    run(SAU_OP_SUB_WORD, 32'h80000000, 32'h1, 0, 0, 0);
    run(SAU_OP_ADD_HALVES, 32'h12345678, 32'h11111111, 0, 0, 0);
    // a request with the clock enable low must be ignored
    dec.idle();
    dec.issue(SAU_OP_ADD_WORD, 1, 2, 0, 0, 0, 1'b0);
    dec.idle();
    for (int i = 0; i < 300; i++) begin
      run(sau_op_t'($urandom % 10), $urandom, $urandom, $urandom % 34, $urandom % 32, $urandom % 2);
      if (i % 37 == 0) wst($urandom % 2, 4'($urandom));
    end
    repeat (4) dec.idle();
    `CHK("pending", 0, exp_q.size())
    summarize();
  end
endmodule
